//--- event_channel.sv
`timescale 1ns/100ps
module event_channel (
  // Clock
  input  wire logic       mclk,
  // Pulse request from the bench
  input  wire logic       go,
  input  wire logic [7:0] width,
  // Shared channel level
  output logic            level
);
  int left = 0;

  initial level = 1'h0;

  // One channel feeds both timer inputs: each pulse gives a rising and a falling edge
  always @(posedge mclk) begin
    if (go) begin
      level <= 1'h1;
      left  <= width;
    end else if (left > 1) begin
      left <= left - 1;
    end else begin
      level <= 1'h0;
      left  <= 0;
    end
  end
endmodule

//--- pwm_timer_capture.sv
`include "timer_capture_defs.svh"
`timescale 1ns/100ps
module pwm_timer_capture
  import timer_capture_pkg::*;
#(
  // Unlock key value is arbitrary
  parameter logic [7:0] IoRegisterKey = 8'hD8
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        porResetn,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  // Event inputs, sleep state and fuse
  input  wire logic        eventInA,
  input  wire logic        eventInB,
  input  wire logic [1:0]  sleepMode,
  input  wire logic [7:0]  fuseCfg,
  // Waveform pins
  output logic             waveformOutA,
  output logic             waveformOutAOe,
  output logic             waveformOutB,
  output logic             waveformOutBOe,
  // Output events
  output logic             eventBClear,
  output logic             eventASet,
  output logic             eventBSet,
  output logic             eventProgrammable,
  // Interrupt requests
  output logic             cycleDoneIrq,
  output logic             onTimeEntryIrq
);

  state_type q;
  state_type d;

  logic       busReq;
  logic       wrReq;
  logic [5:0] idx;
  logic [7:0] wdat;
  logic       run;
  logic       restart;
  logic       onEntry;
  logic       trigSrc;
  logic [2:0] preLast;
  logic [1:0] evIn;
  logic [1:0] newLvl;
  logic [1:0] edgeEv;
  logic [1:0] capEv;
  logic [1:0] swFire;
  phase_type  ph;

  assign evIn = {eventInB, eventInA};
  assign idx  = adr_i[7:2];
  assign wdat = dat_i[7:0];

  always_comb begin
    d       = q;
    busReq  = cyc_i && stb_i && !q.ack;
    wrReq   = busReq && we_i && sel_i[0];
    run     = q.enable && (sleepMode < `SLEEP_STANDBY);
    d.ack   = busReq;
    d.rdData = `RESET_BYTE;

    // Event pins: three flops, level taken when the last two agree
    for (int i = 0; i < 2; i++) begin
      d.evSync[i] = {q.evSync[i][1:0], evIn[i]};
      newLvl[i]   = (q.evSync[i][1] == q.evSync[i][2]) ? q.evSync[i][2] : q.evLvl[i];
      d.evLvl[i]  = newLvl[i];
      edgeEv[i]   = (newLvl[i] != q.evLvl[i]) && (newLvl[i] != q.event_input_config[i][`BIT_EDGE]);
      capEv[i]    = edgeEv[i] && q.event_input_config[i][`BIT_ACTION];
      swFire[i]   = (q.cmd == CMD_DONE) && q.swCapReq[i];
    end

    // Software capture command crossing
    case (q.cmd)
      CMD_SYNC: d.cmd = CMD_DONE;
      CMD_DONE: begin
        d.cmd      = CMD_IDLE;
        d.swCapReq = 2'b00;
      end
      default: d.cmd = CMD_IDLE;
    endcase

    // Protection window counts bus accesses
    if (wrReq && idx == `IDX_PROTECT && wdat == IoRegisterKey) begin
      d.protCnt = `PROTECT_WINDOW;
    end else if (busReq && q.protCnt != 3'h0) begin
      d.protCnt = q.protCnt - 3'h1;
    end

    // Register writes
    if (wrReq) begin
      case (idx)
        `IDX_CTRLA:    d.enable = wdat[`BIT_ENABLE];
        `IDX_CONTROL_C_REG:    d.override = wdat[`BIT_OVERRIDE];
        `IDX_OVERRIDE_VALUE_REG:    d.ovrVal = wdat;
        `IDX_COMMAND_REG: begin
          if (wdat[`BIT_SCAPA] || wdat[`BIT_SCAPB]) begin
            d.swCapReq = d.swCapReq | wdat[`BIT_SCAPB:`BIT_SCAPA];
            if (d.cmd == CMD_IDLE) begin
              d.cmd = CMD_SYNC;
            end
          end
        end
        `IDX_EVCTRLA:  d.event_input_config[0] = wdat;
        `IDX_EVCTRLB:  d.event_input_config[1] = wdat;
        `IDX_IRQ_ENABLE_REG:  d.irqEn = wdat[3:0] & `IRQ_EN_MASK;
        `IDX_IRQ_FLAG_REG: d.flags = q.flags & ~wdat[3:0];
        `IDX_INPUTB:   d.inModeB = wdat[3:0];
        `IDX_FAULT: begin
          if (q.protCnt != 3'h0) begin
            d.fault_output_reg = wdat;
          end
        end
        `IDX_DELAY_CONTROL_REG:  d.delay_control_reg = wdat[5:0];
        `IDX_DELAY_VALUE:   d.delay_value = wdat;
        default: begin
          if (idx[5:3] == `IDX_CMP_BASE) begin
            if (idx[0]) begin
              d.cmp[idx[2:1]][11:8] = wdat[3:0];
            end else begin
              d.cmp[idx[2:1]][7:0] = wdat;
            end
          end
        end
      endcase
    end

    // Register reads
    if (busReq && !we_i) begin
      case (idx)
        `IDX_CTRLA:    d.rdData = {7'h00, q.enable};
        `IDX_CONTROL_C_REG:    d.rdData = {7'h00, q.override};
        `IDX_OVERRIDE_VALUE_REG:    d.rdData = q.ovrVal;
        `IDX_EVCTRLA:  d.rdData = q.event_input_config[0];
        `IDX_EVCTRLB:  d.rdData = q.event_input_config[1];
        `IDX_IRQ_ENABLE_REG:  d.rdData = {4'h0, q.irqEn};
        `IDX_IRQ_FLAG_REG: d.rdData = {4'h0, q.flags};
        `IDX_STATUS: begin
          d.rdData[`BIT_COMMAND_READY] = (q.cmd == CMD_IDLE);
          d.rdData[`BIT_ENRDY]  = 1'b1;
        end
        `IDX_INPUTB:   d.rdData = {4'h0, q.inModeB};
        `IDX_FAULT:    d.rdData = q.fault_output_reg;
        `IDX_DELAY_CONTROL_REG:  d.rdData = {2'h0, q.delay_control_reg};
        `IDX_DELAY_VALUE:   d.rdData = q.delay_value;
        `IDX_CAPAL: begin
          d.rdData    = q.capture[0][7:0];
          d.capHiTemp = q.capture[0][11:8];
        end
        `IDX_CAPBL: begin
          d.rdData    = q.capture[1][7:0];
          d.capHiTemp = q.capture[1][11:8];
        end
        `IDX_CAPAH,
        `IDX_CAPBH:    d.rdData = {4'h0, q.capHiTemp};
        default: begin
          if (idx[5:3] == `IDX_CMP_BASE) begin
            d.rdData = idx[0] ? {4'h0, q.cmp[idx[2:1]][11:8]} : q.cmp[idx[2:1]][7:0];
          end
        end
      endcase
    end

    // Captures: event or software strobe, value held in bus domain
    for (int i = 0; i < 2; i++) begin
      if (capEv[i] || swFire[i]) begin
        d.capture[i] = q.count;
      end
      if (capEv[i]) begin
        d.flags[`BIT_FLAG_CAPTURE_FLAG_A + i] = 1'b1;
      end
    end

    // Counter, one-ramp sequence
    restart = edgeEv[1] && (q.inModeB == `MODE_RESTART);
    if (run) begin
      if (restart || q.count == q.cmp[3]) begin
        d.count = 12'h000;
        if (!restart) begin
          d.flags[`BIT_FLAG_OVF] = 1'b1;
        end
      end else begin
        d.count = q.count + 12'h001;
      end
    end
    if (d.count < q.cmp[0]) begin
      ph = PH_DTA;
    end else if (d.count < q.cmp[1]) begin
      ph = PH_OTA;
    end else if (d.count < q.cmp[2]) begin
      ph = PH_DTB;
    end else begin
      ph = PH_OTB;
    end
    onEntry = 1'b0;
    if (run) begin
      d.phase = ph;
      if (ph == PH_OTA && q.phase != PH_OTA) begin
        d.flags[`BIT_FLAG_CAPTURE_FLAG_A] = 1'b1;
        onEntry = 1'b1;
      end
      if (ph == PH_OTB && q.phase != PH_OTB) begin
        d.flags[`BIT_FLAG_CAPTURE_FLAG_B] = 1'b1;
        onEntry = 1'b1;
      end
    end

    // Compare match strobes
    d.cmpEvent[0] = run && (d.count == q.cmp[3]);
    d.cmpEvent[1] = run && (d.count == q.cmp[0]);
    d.cmpEvent[2] = run && (d.count == q.cmp[2]);

    // Programmable event with optional delay
    case (q.delay_control_reg[3:2])
      2'h0:    trigSrc = d.cmpEvent[1];
      2'h1:    trigSrc = run && (d.count == q.cmp[1]);
      2'h2:    trigSrc = onEntry;
      default: trigSrc = d.cmpEvent[0];
    endcase
    preLast = (3'h1 << q.delay_control_reg[5:4]) - 3'h1;
    d.progEvent = 1'b0;
    if (q.delay_control_reg[1:0] == `DLYSEL_BLANK) begin
      d.progEvent = onEntry;
    end else if (q.delay_control_reg[1:0] == `DLYSEL_EVENT) begin
      if (q.delay_control_reg[3:2] != `DELAY_TRIGGER_SEL_DELAY) begin
        d.progEvent = trigSrc;
      end else if (trigSrc && !q.dlyBusy) begin
        d.dlyBusy = 1'b1;
        d.dlyCnt  = 8'h00;
        d.dlyPre  = 3'h0;
      end
    end
    if (q.dlyBusy) begin
      if (q.dlyCnt == q.delay_value) begin
        d.progEvent = 1'b1;
        d.dlyBusy   = 1'b0;
      end else if (q.dlyPre == preLast) begin
        d.dlyPre = 3'h0;
        d.dlyCnt = q.dlyCnt + 8'h01;
      end else begin
        d.dlyPre = q.dlyPre + 3'h1;
      end
    end

    // Waveform outputs
    for (int i = 0; i < 2; i++) begin
      d.woOe[i] = q.fault_output_reg[`BIT_OUTEN_A + i];
    end
    if (!q.enable) begin
      d.wo[0] = q.fault_output_reg[`BIT_LEVEL_A];
      d.wo[1] = q.fault_output_reg[`BIT_LEVEL_A + 1];
    end else if (q.override) begin
      d.wo[0] = (q.phase == PH_OTA) ? q.ovrVal[1] : q.ovrVal[0];
      d.wo[1] = (q.phase == PH_OTB) ? q.ovrVal[7] : q.ovrVal[6];
    end else begin
      d.wo[0] = (q.phase == PH_OTA);
      d.wo[1] = (q.phase == PH_OTB);
    end

    // Interrupt requests
    d.irqCycleDone   = q.flags[`BIT_FLAG_OVF] && q.irqEn[`BIT_FLAG_OVF];
    d.irqOnTimeEntry = (q.flags[`BIT_FLAG_CAPTURE_FLAG_A] && q.irqEn[`BIT_FLAG_CAPTURE_FLAG_A]) ||
                       (q.flags[`BIT_FLAG_CAPTURE_FLAG_B] && q.irqEn[`BIT_FLAG_CAPTURE_FLAG_B]);

    if (!resetn) begin
      d           = '0;
      d.fault_output_reg = porResetn ? fuseCfg : `RESET_BYTE;
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign ack_o             = q.ack;
  assign dat_o             = {24'h000000, q.rdData};
  assign waveformOutA      = q.wo[0];
  assign waveformOutB      = q.wo[1];
  assign waveformOutAOe    = q.woOe[0];
  assign waveformOutBOe    = q.woOe[1];
  assign eventBClear       = q.cmpEvent[0];
  assign eventASet         = q.cmpEvent[1];
  assign eventBSet         = q.cmpEvent[2];
  assign eventProgrammable = q.progEvent;
  assign cycleDoneIrq      = q.irqCycleDone;
  assign onTimeEntryIrq    = q.irqOnTimeEntry;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence swCmdStart;
    q.cmd == CMD_IDLE ##1 q.cmd == CMD_SYNC;
  endsequence

  sequence swCmdFinish;
    (q.cmd != CMD_IDLE) [*2] ##1 (q.cmd == CMD_IDLE);
  endsequence

  capture_flag_a: assert property (capEv[0] |=> q.flags[`BIT_FLAG_CAPTURE_FLAG_A])
    else $error("capture A did not raise its flag");

  command_busy_a: assert property (swCmdStart |-> swCmdFinish)
    else $error("command ready not low for the crossing");

  restart_count_a: assert property (run && restart |=> q.count == 12'h000)
    else $error("input B restart did not clear counter");

  fault_level_a: assert property (!q.enable |=> waveformOutA == $past(q.fault_output_reg[0]))
    else $error("disabled output not at fault level");

  override_out_a: assert property (q.enable && q.override && q.phase == PH_OTB
                                    |=> waveformOutB == $past(q.ovrVal[7]))
    else $error("override value not driven on output B");

  match_strobe_a: assert property (eventBClear && q.cmp[3] != 12'h000 |=> !eventBClear)
    else $error("compare strobe longer than one cycle");

  delay_done_a: assert property (q.dlyBusy && q.dlyCnt == q.delay_value
                                  |=> eventProgrammable && !q.dlyBusy)
    else $error("delayed event not sent at count end");

  irq_hold_a: assert property (q.flags[`BIT_FLAG_OVF] && q.irqEn[`BIT_FLAG_OVF]
                                |=> cycleDoneIrq)
    else $error("cycle-done request missing");

  sleep_stop_a: assert property (sleepMode >= `SLEEP_STANDBY |=> $stable(q.count))
    else $error("counter moved in deep sleep");

  protect_write_a: assert property (wrReq && idx == `IDX_FAULT && q.protCnt == 3'h0
                                     |=> $stable(q.fault_output_reg))
    else $error("unprotected fault register write took effect");

endmodule

//--- testbench.sv
`timescale 1ns/100ps
`include "timer_capture_defs.svh"
module testbench;
  logic        mclk      = 1'h0;
  logic        resetn    = 1'h0;
  logic        porResetn = 1'h0;
  logic        cyc       = 1'h0;
  logic        stb       = 1'h0;
  logic        we        = 1'h0;
  logic [7:0]  adr       = 8'h00;
  logic [31:0] dat       = 32'h0;
  logic [1:0]  sleepMode = 2'h0;
  logic [7:0]  fuseCfg   = 8'h00;
  logic        go        = 1'h0;
  logic [7:0]  width     = 8'h04;
  logic        ackO, waveform_out_a, woAOe, waveform_out_b, woBOe, evLevel, cycleDoneIrq, onTimeEntryIrq;
  logic [31:0] datO;
  logic [7:0]  rd, nv;
  logic [11:0] a1, b1, a2, a3, a4;
  int          errors = 0;
  int          checks = 0;
  int          cycN = 0;
  int          tAck, t1, t2;
  int          seed = 32'h815240fd;

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) cycN <= cycN + 1;

  event_channel u_event_channel (.mclk(mclk), .go(go), .width(width), .level(evLevel));

  pwm_timer_capture u_pwm_timer_capture (
    .mclk(mclk), .resetn(resetn), .porResetn(porResetn),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
    .ack_o(ackO), .dat_o(datO), .eventInA(evLevel), .eventInB(evLevel),
    .sleepMode(sleepMode), .fuseCfg(fuseCfg),
    .waveformOutA(waveform_out_a), .waveformOutAOe(woAOe), .waveformOutB(waveform_out_b), .waveformOutBOe(woBOe),
    .eventBClear(), .eventASet(), .eventBSet(), .eventProgrammable(),
    .cycleDoneIrq(cycleDoneIrq), .onTimeEntryIrq(onTimeEntryIrq)
  );

  task automatic end_of_test;
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: pin %b, want %b", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we  <= w;
    adr <= {idx, 2'h0};
    dat <= {24'h000000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ackO !== 1'h1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("unexpected at %0t: no ack", $time);
    end
    rd   = datO[7:0];
    tAck = cycN;
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
  endtask

  task automatic do_reset(input logic por);
    @(posedge mclk);
    resetn    <= 1'h0;
    porResetn <= por;
    repeat (2) @(posedge mclk);
    resetn    <= 1'h1;
    porResetn <= 1'h1;
    @(posedge mclk);
  endtask

  task automatic pins(input logic [7:0] f);
    chk_pin(woAOe, f[`BIT_OUTEN_A]);
    chk_pin(woBOe, f[`BIT_OUTEN_A + 1]);
    chk_pin(waveform_out_a, f[`BIT_LEVEL_A]);
    chk_pin(waveform_out_b, f[`BIT_LEVEL_A + 1]);
  endtask

  // Strobe a software capture and wait for the command to complete
  task automatic swcap(input logic [7:0] cmd, output int t);
    int n;
    bus(1'h1, `IDX_COMMAND_REG, cmd);
    t = tAck;
    n = 0;
    do begin
      bus(1'h0, `IDX_STATUS, 8'h00);
      n++;
    end while (rd[`BIT_COMMAND_READY] !== 1'h1 && n < 10);
    chk_val(rd[`BIT_COMMAND_READY], 12'h001);
  endtask

  // Low byte first: it latches the high nibble
  task automatic cap(input logic [5:0] lo, output logic [11:0] v);
    logic [7:0] l;
    bus(1'h0, lo, 8'h00);
    l = rd;
    bus(1'h0, lo + 6'h01, 8'h00);
    v = {rd[3:0], l};
  endtask

  task automatic unlock(input int reads);
    bus(1'h1, `IDX_PROTECT, 8'hD8);
    repeat (reads) bus(1'h0, `IDX_STATUS, 8'h00);
  endtask

  initial begin
    #100us;
    errors++;
    $display("unexpected at %0t: timeout", $time);
    end_of_test;
  end

  initial begin
    do_reset(1'h0);
    bus(1'h0, `IDX_FAULT, 8'h00);
    chk_val(rd, 12'h000);
    bus(1'h0, `IDX_STATUS, 8'h00);
    chk_val(rd, 12'h003);
    bus(1'h0, 6'h01, 8'h00);
    chk_val(rd, 12'h000);
    fuseCfg <= 8'($random(seed));
    nv = 8'($random(seed));
    do_reset(1'h1);
    bus(1'h0, `IDX_FAULT, 8'h00);
    chk_val(rd, {4'h0, fuseCfg});
    pins(fuseCfg);
    bus(1'h1, `IDX_FAULT, nv);
    bus(1'h0, `IDX_FAULT, 8'h00);
    chk_val(rd, {4'h0, fuseCfg});
    unlock(3);
    bus(1'h1, `IDX_FAULT, nv);
    bus(1'h0, `IDX_FAULT, 8'h00);
    chk_val(rd, {4'h0, nv});
    pins(nv);
    unlock(4);
    bus(1'h1, `IDX_FAULT, ~nv);
    bus(1'h0, `IDX_FAULT, 8'h00);
    chk_val(rd, {4'h0, nv});
    bus(1'h1, `IDX_EVCTRLA, 8'h04);
    bus(1'h1, `IDX_EVCTRLB, 8'h14);
    bus(1'h1, `IDX_IRQ_ENABLE_REG, 8'h0C);
    width <= 8'h04 + 8'($random(seed) & 15);
    go    <= 1'h1;
    @(posedge mclk);
    go    <= 1'h0;
    repeat (40) @(posedge mclk);
    bus(1'h0, `IDX_IRQ_FLAG_REG, 8'h00);
    chk_val(rd, 12'h00C);
    chk_pin(onTimeEntryIrq, 1'h1);
    chk_pin(cycleDoneIrq, 1'h0);
    bus(1'h1, `IDX_IRQ_FLAG_REG, 8'h04);
    bus(1'h0, `IDX_IRQ_FLAG_REG, 8'h00);
    chk_val(rd, 12'h008);
    chk_pin(onTimeEntryIrq, 1'h1);
    bus(1'h1, `IDX_IRQ_ENABLE_REG, 8'h04);
    repeat (2) @(posedge mclk);
    chk_pin(onTimeEntryIrq, 1'h0);
    bus(1'h1, `IDX_IRQ_FLAG_REG, 8'h08);
    bus(1'h0, `IDX_IRQ_FLAG_REG, 8'h00);
    chk_val(rd, 12'h000);
    bus(1'h1, 6'h2E, 8'hFF);
    bus(1'h1, 6'h2F, 8'h0F);
    sleepMode <= 2'h1;
    bus(1'h1, `IDX_CTRLA, 8'h01);
    swcap(8'h18, t1);
    cap(`IDX_CAPAL, a1);
    cap(`IDX_CAPBL, b1);
    chk_val(b1, a1);
    swcap(8'h08, t2);
    cap(`IDX_CAPAL, a2);
    chk_val(a2, 12'(a1 + t2 - t1));
    sleepMode <= 2'h2;
    swcap(8'h08, t1);
    cap(`IDX_CAPAL, a3);
    swcap(8'h10, t2);
    cap(`IDX_CAPBL, a4);
    chk_val(a4, a3);
    // Override bits 0 and 2 of each field follow the fault levels
    bus(1'h1, `IDX_OVERRIDE_VALUE_REG, {~nv[1], nv[1], 1'h0, nv[1], 1'h0, nv[0], ~nv[0], nv[0]});
    bus(1'h1, `IDX_CONTROL_C_REG, 8'h01);
    repeat (2) @(posedge mclk);
    chk_pin(waveform_out_a, nv[0]);
    chk_pin(waveform_out_b, ~nv[1]);
    end_of_test;
  end
endmodule

//--- timer_capture_defs.svh
`ifndef TIMER_CAPTURE_DEFS_SVH
`define TIMER_CAPTURE_DEFS_SVH

// Register indexes; the byte address is four times the index
`define IDX_CTRLA      6'h00
`define IDX_CONTROL_C_REG      6'h02
`define IDX_OVERRIDE_VALUE_REG      6'h03
`define IDX_COMMAND_REG      6'h04
`define IDX_EVCTRLA    6'h08
`define IDX_EVCTRLB    6'h09
`define IDX_IRQ_ENABLE_REG    6'h0C
`define IDX_IRQ_FLAG_REG   6'h0D
`define IDX_STATUS     6'h0E
`define IDX_INPUTB     6'h11
`define IDX_FAULT      6'h12
`define IDX_DELAY_CONTROL_REG    6'h14
`define IDX_DELAY_VALUE     6'h15
`define IDX_CAPAL      6'h22
`define IDX_CAPAH      6'h23
`define IDX_CAPBL      6'h24
`define IDX_CAPBH      6'h25
`define IDX_CMP_BASE   3'h5
`define IDX_PROTECT    6'h30

// Field positions
`define BIT_ENABLE     0
`define BIT_OVERRIDE   0
`define BIT_SCAPA      3
`define BIT_SCAPB      4
`define BIT_ACTION     2
`define BIT_EDGE       4
`define BIT_FLAG_OVF   0
`define BIT_FLAG_CAPTURE_FLAG_A 2
`define BIT_FLAG_CAPTURE_FLAG_B 3
`define BIT_COMMAND_READY     1
`define BIT_ENRDY      0
`define BIT_LEVEL_A    0
`define BIT_OUTEN_A    4
`define IRQ_EN_MASK    4'hD

// Encodings and counts
`define MODE_RESTART   4'h8
`define DELAY_TRIGGER_SEL_DELAY  2'h2
`define DLYSEL_BLANK   2'h1
`define DLYSEL_EVENT   2'h2
`define SLEEP_STANDBY  2'h2
`define PROTECT_WINDOW 3'h4
`define RESET_BYTE     8'h00

`endif

//--- timer_capture_pkg.sv
package timer_capture_pkg;

  typedef enum logic [1:0] {
    PH_DTA = 2'b00,
    PH_OTA = 2'b01,
    PH_DTB = 2'b11,
    PH_OTB = 2'b10
  } phase_type;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_SYNC = 2'b01,
    CMD_DONE = 2'b11
  } cmd_type;

  typedef struct packed {
    logic             ack;
    logic [7:0]       rdData;
    logic             enable;
    logic             override;
    logic [7:0]       ovrVal;
    logic [1:0][7:0]  event_input_config;
    logic [3:0]       irqEn;
    logic [3:0]       flags;
    logic [3:0]       inModeB;
    logic [7:0]       fault_output_reg;
    logic [5:0]       delay_control_reg;
    logic [7:0]       delay_value;
    logic [3:0][11:0] cmp;
    logic [1:0][11:0] capture;
    logic [3:0]       capHiTemp;
    logic [2:0]       protCnt;
    cmd_type          cmd;
    logic [1:0]       swCapReq;
    logic [11:0]      count;
    phase_type        phase;
    logic [1:0][2:0]  evSync;
    logic [1:0]       evLvl;
    logic [1:0]       wo;
    logic [1:0]       woOe;
    logic [2:0]       cmpEvent;
    logic             progEvent;
    logic             dlyBusy;
    logic [7:0]       dlyCnt;
    logic [2:0]       dlyPre;
    logic             irqCycleDone;
    logic             irqOnTimeEntry;
  } state_type;

endpackage
